// ===== src/encl_entry_track.sv
// Purpose : Holds the entry kind and last enter/resume address of this thread
// Assumes : Core reports each retired enclave operation once
// Notes   : Entry kind cleared on any enclave exit; last entry address is kept
`timescale 1ns/10ps
module encl_entry_track
    import encl_pm_pkg::*;
(
    input  wire logic                       i_clk,
    input  wire logic                       i_rstn,
    input  wire encl_pm_pkg::retire_t       i_ret,
    output logic                            o_opt_in,
    output logic                            o_opt_out,
    output logic [encl_pm_pkg::ADDR_W-1:0]  o_last_entry_addr
);
    import encl_pm_pkg::*;

    entry_kind_t        kind_reg;
    logic [ADDR_W-1:0]  entry_addr_reg;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            kind_reg <= ENT_NONE;
        else if (i_ret.valid && i_ret.kind == OP_ENTER_RESUME)
            kind_reg <= i_ret.opt_out ? ENT_OPT_OUT : ENT_OPT_IN;
        else if (i_ret.valid && (i_ret.kind == OP_EXIT_LEAF || i_ret.kind == OP_ASYNC_EXIT))
            kind_reg <= ENT_NONE;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            entry_addr_reg <= ADDR_RST;
        else if (i_ret.valid && i_ret.kind == OP_ENTER_RESUME)
            entry_addr_reg <= i_ret.instr_addr;
    end

    assign o_opt_in          = (kind_reg == ENT_OPT_IN);
    assign o_opt_out         = (kind_reg == ENT_OPT_OUT);
    assign o_last_entry_addr = entry_addr_reg;

endmodule : encl_entry_track

// ===== src/encl_pm_gate.sv
// Purpose : Gates counters and precise sampling around enclave entry and exit
// Assumes : Counter logic and sample writer outside; this block steers them
// Notes   : All outputs registered, one cycle after the causing retire
//
// Behaviour
// - Opt-in entry: counting normal, status bit not set
// - Opt-out stops fixed 0 and general counters
// - Opt-out suppresses samples, sets status bit
// - Sibling all-thread counters demoted during opt-out
// - Any exit lifts all suppression
// - Exit restores sibling all-thread counting
// - Supervisor and key/report ops report own address
// - Enter/resume: opt-in reports, opt-out suppresses
// - Exit-leaf sample address by entry kind
// - Async-exit sample address by entry kind
// - Sample after exit delivery uses landing address
// - Async-exit buffer faults dropped, record aborted
// - Async-exit buffer traps held to boundary
// - Exit event delivery continues after abort
// - Opt-in enclave ops count branch and instruction
// - Opt-out enclave counts one branch, one instruction
// - Shared-core counters unaffected by entry
// - Outside window, buffer faults reported, record skipped
// - Status bit clear means counts are normal
`timescale 1ns/10ps
module encl_pm_gate
    import encl_pm_pkg::*;
(
    input  wire logic                                   i_clk,
    input  wire logic                                   i_rstn,
    input  wire encl_pm_pkg::retire_t                   i_ret,
    input  wire logic                                   i_sample_pending,
    input  wire logic                                   i_status_clear,
    input  wire logic [encl_pm_pkg::NUM_FIXED-1:0]      i_sib_fixed_any,
    input  wire logic [encl_pm_pkg::NUM_GP-1:0]         i_sib_gp_any,
    input  wire logic                                   i_sib_opt_out,
    input  wire logic                                   i_shared_cnt_en,
    input  wire logic                                   i_exit_window,
    input  wire encl_pm_pkg::store_evt_t                i_store_evt,
    input  wire logic                                   i_boundary,
    output logic [encl_pm_pkg::NUM_FIXED-1:0]           o_fixed_run,
    output logic [encl_pm_pkg::NUM_GP-1:0]              o_gp_run,
    output logic [encl_pm_pkg::NUM_FIXED-1:0]           o_sib_fixed_any_eff,
    output logic [encl_pm_pkg::NUM_GP-1:0]              o_sib_gp_any_eff,
    output logic                                        o_shared_cnt_en,
    output logic                                        o_sample_suppress,
    output logic                                        o_side_channel_status_bit,
    output encl_pm_pkg::sample_t                        o_sample,
    output logic [1:0]                                  o_branch_inc,
    output logic [1:0]                                  o_instr_inc,
    output logic                                        o_record_abort,
    output logic                                        o_fault_report,
    output logic                                        o_trap_release,
    output logic                                        o_exit_delivery_go
);
    import encl_pm_pkg::*;

    // ------------------------------------------------------------
    // Entry state and buffer store faults
    // ------------------------------------------------------------
    logic               opt_in;
    logic               opt_out;
    logic [ADDR_W-1:0]  last_entry_addr;
    logic               abort;
    logic               report_now;
    logic               trap_rel;

    encl_entry_track u_track (
        .i_clk             (i_clk),
        .i_rstn            (i_rstn),
        .i_ret             (i_ret),
        .o_opt_in          (opt_in),
        .o_opt_out         (opt_out),
        .o_last_entry_addr (last_entry_addr)
    );

    encl_store_fault u_fault (
        .i_clk          (i_clk),
        .i_rstn         (i_rstn),
        .i_exit_window  (i_exit_window),
        .i_evt          (i_store_evt),
        .i_boundary     (i_boundary),
        .o_abort        (abort),
        .o_report_now   (report_now),
        .o_trap_release (trap_rel)
    );

    function automatic logic is_exit(input retire_t r);
        is_exit = r.valid && (r.kind == OP_EXIT_LEAF || r.kind == OP_ASYNC_EXIT);
    endfunction : is_exit

    // Suppression follows the state the next cycle will have
    logic entering_out;
    logic out_next;
    assign entering_out = i_ret.valid && i_ret.kind == OP_ENTER_RESUME && i_ret.opt_out;
    assign out_next = entering_out || (opt_out && !is_exit(i_ret));

    // ------------------------------------------------------------
    // Counter run enables
    // ------------------------------------------------------------
    logic [NUM_FIXED-1:0] fixed_run_reg;
    logic [NUM_GP-1:0]    gp_run_reg;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FIXED; gi++)
        begin : g_fixed
            always_ff @(posedge i_clk or negedge i_rstn)
            begin
                if (!i_rstn)
                    fixed_run_reg[gi] <= 1'b1;
                else if (gi == FIXED_CYC_LO || gi == FIXED_CYC_HI)
                    fixed_run_reg[gi] <= 1'b1;
                else
                    fixed_run_reg[gi] <= !out_next;
            end
        end
        for (gi = 0; gi < NUM_GP; gi++)
        begin : g_gp
            always_ff @(posedge i_clk or negedge i_rstn)
            begin
                if (!i_rstn)
                    gp_run_reg[gi] <= 1'b1;
                else
                    gp_run_reg[gi] <= !out_next;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Sibling demotion
    // ------------------------------------------------------------
    logic [NUM_FIXED-1:0] sib_fixed_reg;
    logic [NUM_GP-1:0]    sib_gp_reg;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sib_fixed_reg <= '0;
            sib_gp_reg    <= '0;
        end
        else
        begin
            sib_fixed_reg <= out_next ? '0 : i_sib_fixed_any;
            sib_gp_reg    <= out_next ? '0 : i_sib_gp_any;
        end
    end

    // ------------------------------------------------------------
    // Suppression and status bit
    // ------------------------------------------------------------
    logic suppress_reg;
    logic status_reg;
    logic shared_reg;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            suppress_reg <= 1'b0;
        else
            suppress_reg <= out_next;
    end

    // Status bit sets, set beats clear
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            status_reg <= 1'b0;
        else if (out_next)
            status_reg <= 1'b1;
        else if (i_status_clear)
            status_reg <= 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            shared_reg <= 1'b0;
        else
            shared_reg <= i_shared_cnt_en;
    end

    // ------------------------------------------------------------
    // Sample record and eventing address
    // ------------------------------------------------------------
    sample_t            sample_next;
    sample_t            sample_reg;

    always_comb
    begin
        sample_next = '0;
        if (i_ret.valid && i_sample_pending)
        begin
            unique case (i_ret.kind)
                OP_SUPERVISOR, OP_KEY_OR_REPORT:
                begin
                    sample_next.valid            = !opt_out;
                    sample_next.eventing_address = i_ret.instr_addr;
                end
                OP_ENTER_RESUME:
                begin
                    sample_next.valid            = !i_ret.opt_out;
                    sample_next.eventing_address = i_ret.instr_addr;
                end
                OP_EXIT_LEAF:
                begin
                    sample_next.valid            = 1'b1;
                    sample_next.eventing_address = opt_out ? last_entry_addr : i_ret.instr_addr;
                end
                OP_ASYNC_EXIT:
                begin
                    sample_next.valid            = !abort;
                    sample_next.eventing_address = opt_out ? last_entry_addr : i_ret.saved_state_addr;
                end
                OP_EXIT_DELIVERY_END:
                begin
                    sample_next.valid            = 1'b1;
                    sample_next.eventing_address = i_ret.landing_addr;
                end
                OP_OTHER:
                begin
                    sample_next.valid            = !opt_out;
                    sample_next.eventing_address = i_ret.instr_addr;
                end
                default:
                begin
                    sample_next.valid            = 1'b0;
                    sample_next.eventing_address = ADDR_RST;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            sample_reg <= '0;
        else
            sample_reg <= sample_next;
    end

    // ------------------------------------------------------------
    // Branch and instruction increments
    // ------------------------------------------------------------
    logic [1:0] branch_reg;
    logic [1:0] instr_reg;
    logic       enclave_op;

    // Opt-out body is invisible; only its exit stands for it
    assign enclave_op = i_ret.valid && (i_ret.kind == OP_ENTER_RESUME || is_exit(i_ret));

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            branch_reg <= 2'h0;
            instr_reg  <= 2'h0;
        end
        else if (enclave_op && !entering_out)
        begin
            branch_reg <= RETIRE_ONE;
            instr_reg  <= RETIRE_ONE;
        end
        else
        begin
            branch_reg <= 2'h0;
            instr_reg  <= 2'h0;
        end
    end

    // ------------------------------------------------------------
    // Fault outcome and exit delivery
    // ------------------------------------------------------------
    logic abort_reg;
    logic report_reg;
    logic trap_reg;
    logic deliver_reg;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            abort_reg   <= 1'b0;
            report_reg  <= 1'b0;
            trap_reg    <= 1'b0;
            deliver_reg <= 1'b0;
        end
        else
        begin
            abort_reg   <= abort;
            report_reg  <= report_now;
            trap_reg    <= trap_rel;
            deliver_reg <= i_ret.valid && i_ret.kind == OP_ASYNC_EXIT;
        end
    end

    assign o_side_channel_status_bit = status_reg;
    assign o_fixed_run               = fixed_run_reg;
    assign o_gp_run                  = gp_run_reg;
    assign o_sib_fixed_any_eff       = sib_fixed_reg;
    assign o_sib_gp_any_eff          = sib_gp_reg;
    assign o_shared_cnt_en           = shared_reg;
    assign o_sample_suppress         = suppress_reg;
    assign o_sample                  = sample_reg;
    assign o_branch_inc              = branch_reg;
    assign o_instr_inc               = instr_reg;
    assign o_record_abort            = abort_reg;
    assign o_fault_report            = report_reg;
    assign o_trap_release            = trap_reg;
    assign o_exit_delivery_go        = deliver_reg;

endmodule : encl_pm_gate

// ===== src/encl_pm_pkg.sv
// Purpose : Shared types and constants for enclave performance-monitor gating
// Assumes : One logical processor per instance, sibling state arrives as plain ports
// Notes   : Addresses are full linear addresses of the core
package encl_pm_pkg;

    localparam int ADDR_W          = 64;
    localparam int NUM_GP          = 8;
    localparam int NUM_FIXED       = 3;
    localparam int STATUS_W        = 64;
    // Position of the side-channel status bit in the global counter status
    localparam int SIDE_CHAN_BIT   = 60;
    localparam int FIXED_CYC_LO    = 1;
    localparam int FIXED_CYC_HI    = 2;
    localparam logic [ADDR_W-1:0] ADDR_RST = 64'h0000_0000_0000_0000;
    localparam logic [1:0] RETIRE_ONE      = 2'h1;

    typedef enum logic [1:0] {
        ENT_NONE,
        ENT_OPT_IN,
        ENT_OPT_OUT
    } entry_kind_t;

    // Kinds of retired operation the core reports
    typedef enum logic [2:0] {
        OP_OTHER,
        OP_SUPERVISOR,
        OP_KEY_OR_REPORT,
        OP_ENTER_RESUME,
        OP_EXIT_LEAF,
        OP_ASYNC_EXIT,
        OP_EXIT_DELIVERY_END
    } op_kind_t;

    typedef struct packed {
        logic              valid;
        op_kind_t          kind;
        logic              opt_out;
        logic [ADDR_W-1:0] instr_addr;
        logic [ADDR_W-1:0] saved_state_addr;
        logic [ADDR_W-1:0] landing_addr;
    } retire_t;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] eventing_address;
    } sample_t;

    typedef struct packed {
        logic fault_like;
        logic trap_like;
    } store_evt_t;

endpackage : encl_pm_pkg

// ===== src/encl_store_fault.sv
// Purpose : Decides what happens to a fault or trap on sample/trace buffer stores
// Assumes : Core flags the async-exit window while records are written
// Notes   : Trap is held until the next instruction boundary
`timescale 1ns/10ps
module encl_store_fault
    import encl_pm_pkg::*;
(
    input  wire logic                     i_clk,
    input  wire logic                     i_rstn,
    input  wire logic                     i_exit_window,
    input  wire encl_pm_pkg::store_evt_t  i_evt,
    input  wire logic                     i_boundary,
    output logic                          o_abort,
    output logic                          o_report_now,
    output logic                          o_trap_release
);
    import encl_pm_pkg::*;

    logic trap_pend_reg;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            trap_pend_reg <= 1'b0;
        else if (i_exit_window && i_evt.trap_like)
            trap_pend_reg <= 1'b1;
        else if (i_boundary)
            trap_pend_reg <= 1'b0;
    end

    assign o_abort        = i_evt.fault_like;
    assign o_report_now   = i_evt.fault_like && !i_exit_window;
    assign o_trap_release = trap_pend_reg && i_boundary;

endmodule : encl_store_fault

// ===== verification/core_retire_model.sv
// Purpose : Core retirement side that feeds retired operations to the gate
// Assumes : Bench calls put or idle once per cycle, just after the rising edge
// Notes   : Idle cycles clear valid and flip every other field so stale addresses never look fresh
`timescale 1ns/10ps
module core_retire_model
    import encl_pm_pkg::*;
(
    output encl_pm_pkg::retire_t o_ret
);
    retire_t ret_reg;

    assign o_ret = ret_reg;

    initial ret_reg = '0;

    task automatic put(input retire_t r);
        ret_reg = r;
    endtask : put

    // Released bus shows a moving pattern, not the last op
    task automatic idle();
        ret_reg = {1'b0, ~ret_reg[$bits(retire_t)-2:0]};
    endtask : idle
endmodule : core_retire_model

// ===== verification/encl_pm_gate_checker.sv
// Purpose : Port-level assertions for the enclave monitor gate
// Assumes : All outputs registered one cycle after their cause
// Notes   : Bound to every instance of the gate
`timescale 1ns/10ps
module encl_pm_gate_checker
    import encl_pm_pkg::*;
(
    input wire logic                              i_clk,
    input wire logic                              i_rstn,
    input wire encl_pm_pkg::retire_t              i_ret,
    input wire logic [encl_pm_pkg::NUM_GP-1:0]    i_sib_gp_any,
    input wire logic                              i_shared_cnt_en,
    input wire logic                              i_exit_window,
    input wire encl_pm_pkg::store_evt_t           i_store_evt,
    input wire logic                              i_boundary,
    input wire logic [encl_pm_pkg::NUM_FIXED-1:0] o_fixed_run,
    input wire logic [encl_pm_pkg::NUM_GP-1:0]    o_gp_run,
    input wire logic [encl_pm_pkg::NUM_GP-1:0]    o_sib_gp_any_eff,
    input wire logic                              o_shared_cnt_en,
    input wire logic                              o_sample_suppress,
    input wire logic                              o_side_channel_status_bit,
    input wire encl_pm_pkg::sample_t              o_sample,
    input wire logic                              o_record_abort,
    input wire logic                              o_fault_report,
    input wire logic                              o_trap_release,
    input wire logic                              o_exit_delivery_go
);
    import encl_pm_pkg::*;
    // ------------------------------------------------------------
    // Entry, exit, sibling, shared-counter and store-fault properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    logic ent_out;
    logic ent_in;
    logic ext;

    assign ent_out = i_ret.valid && i_ret.kind == OP_ENTER_RESUME && i_ret.opt_out;
    assign ent_in  = i_ret.valid && i_ret.kind == OP_ENTER_RESUME && !i_ret.opt_out;
    assign ext     = i_ret.valid && (i_ret.kind == OP_EXIT_LEAF || i_ret.kind == OP_ASYNC_EXIT);

    a_optout_stop: assert property (ent_out |=> o_gp_run == '0 && o_fixed_run == 3'h6)
        else $error("opt-out entry left counters running");
    a_optout_flag: assert property (ent_out |=> o_sample_suppress && o_side_channel_status_bit
        && !o_sample.valid)
        else $error("opt-out entry did not flag or suppress");
    a_optin_normal: assert property (ent_in |=> o_gp_run == '1 && o_fixed_run == 3'h7 && !o_sample_suppress)
        else $error("opt-in entry disturbed counting");
    a_exit_lift: assert property (ext |=> !o_sample_suppress && o_gp_run == '1)
        else $error("exit did not lift suppression");
    a_sib_demote: assert property (o_sample_suppress |-> o_sib_gp_any_eff == '0)
        else $error("sibling all-thread bit kept during opt-out");
    a_sib_restore: assert property ($past(i_rstn) && !o_sample_suppress
        |-> o_sib_gp_any_eff == $past(i_sib_gp_any))
        else $error("sibling all-thread bits not restored");
    a_shared_pass: assert property ($past(i_rstn) |-> o_shared_cnt_en == $past(i_shared_cnt_en))
        else $error("shared counter enable altered");
    a_exit_fault: assert property (i_exit_window && i_store_evt.fault_like
        |=> o_record_abort && !o_fault_report)
        else $error("fault in async exit window mishandled");
    a_store_fault: assert property (!i_exit_window && i_store_evt.fault_like
        |=> o_record_abort && o_fault_report)
        else $error("fault outside window not reported");
    a_trap_boundary: assert property (o_trap_release |-> $past(i_boundary))
        else $error("trap released off a boundary");
    a_exit_deliver: assert property (i_ret.valid && i_ret.kind == OP_ASYNC_EXIT |=> o_exit_delivery_go)
        else $error("exit event delivery not continued");

    c_optout_run: cover property (ent_out ##[1:20] ext);
    c_exit_fault: cover property (i_exit_window && i_store_evt.fault_like);
    c_trap_out: cover property (o_trap_release);
endmodule : encl_pm_gate_checker

bind encl_pm_gate encl_pm_gate_checker u_chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_ret(i_ret), .i_sib_gp_any(i_sib_gp_any),
    .i_shared_cnt_en(i_shared_cnt_en), .i_exit_window(i_exit_window), .i_store_evt(i_store_evt),
    .i_boundary(i_boundary), .o_fixed_run(o_fixed_run), .o_gp_run(o_gp_run),
    .o_sib_gp_any_eff(o_sib_gp_any_eff), .o_shared_cnt_en(o_shared_cnt_en),
    .o_sample_suppress(o_sample_suppress), .o_side_channel_status_bit(o_side_channel_status_bit),
    .o_sample(o_sample), .o_record_abort(o_record_abort), .o_fault_report(o_fault_report),
    .o_trap_release(o_trap_release), .o_exit_delivery_go(o_exit_delivery_go)
);

// ===== verification/tb.sv
// Purpose : Random enclave entry/exit traffic against a bench model
// Assumes : One-cycle output latency on every port
// Notes   : Op counts of ordinary ops are not modelled, only enclave entries and leaves
`timescale 1ns/10ps
module tb;
    import encl_pm_pkg::*;

    logic            i_clk, i_rstn, i_sample_pending, i_status_clear, i_sib_opt_out;
    logic            i_shared_cnt_en, i_exit_window, i_boundary;
    logic [2:0]      i_sib_fixed_any, o_fixed_run, o_sib_fixed_any_eff;
    logic [7:0]      i_sib_gp_any, o_gp_run, o_sib_gp_any_eff;
    logic [1:0]      o_branch_inc, o_instr_inc, e_inc;
    logic            o_shared_cnt_en, o_sample_suppress, o_side_channel_status_bit, o_record_abort;
    logic            o_fault_report, o_trap_release, o_exit_delivery_go;
    retire_t         i_ret;
    store_evt_t      i_store_evt;
    sample_t         o_sample;
    logic [63:0]     last_a, e_sa;
    logic            in_oo, e_st, e_sv, e_ab, e_rep, e_tr, e_go, ptrap, e_sh;
    logic [2:0]      e_sfx;
    logic [7:0]      e_sgp;
    integer          seed = 32'hbc91;
    integer          err_total = 0;
    integer          tests_run = 0;

    core_retire_model u_core (.o_ret(i_ret));

    encl_pm_gate u_dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_ret(i_ret), .i_sample_pending(i_sample_pending),
        .i_status_clear(i_status_clear), .i_sib_fixed_any(i_sib_fixed_any), .i_sib_gp_any(i_sib_gp_any),
        .i_sib_opt_out(i_sib_opt_out), .i_shared_cnt_en(i_shared_cnt_en), .i_exit_window(i_exit_window),
        .i_store_evt(i_store_evt), .i_boundary(i_boundary), .o_fixed_run(o_fixed_run), .o_gp_run(o_gp_run),
        .o_sib_fixed_any_eff(o_sib_fixed_any_eff), .o_sib_gp_any_eff(o_sib_gp_any_eff),
        .o_shared_cnt_en(o_shared_cnt_en), .o_sample_suppress(o_sample_suppress),
        .o_side_channel_status_bit(o_side_channel_status_bit), .o_sample(o_sample),
        .o_branch_inc(o_branch_inc), .o_instr_inc(o_instr_inc), .o_record_abort(o_record_abort),
        .o_fault_report(o_fault_report), .o_trap_release(o_trap_release),
        .o_exit_delivery_go(o_exit_delivery_go)
    );

    always #2.5 i_clk = ~i_clk;

    function automatic logic [31:0] rnd();
        return $random(seed);
    endfunction : rnd

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // One cycle: compare last expectation, drive, predict
    // ------------------------------------------------------------
    task automatic step(input op_kind_t k, input logic v, input logic oo);
        retire_t r;
        logic    f;
        @(posedge i_clk);
        #1;
        check(64'(o_gp_run), in_oo ? 64'h0 : 64'hFF);
        check(64'(o_fixed_run), in_oo ? 64'h6 : 64'h7);
        check(64'(o_sample_suppress), 64'(in_oo));
        check(64'(o_side_channel_status_bit), 64'(e_st));
        check(64'(o_sib_fixed_any_eff), 64'(e_sfx));
        check(64'(o_sib_gp_any_eff), 64'(e_sgp));
        check(64'(o_shared_cnt_en), 64'(e_sh));
        check(64'(o_sample.valid), 64'(e_sv));
        if (e_sv)
            check(o_sample.eventing_address, e_sa);
        check(64'({o_branch_inc, o_instr_inc}), 64'({e_inc, e_inc}));
        check(64'({o_record_abort, o_fault_report, o_trap_release}), 64'({e_ab, e_rep, e_tr}));
        check(64'(o_exit_delivery_go), 64'(e_go));
        r = {1'b1, k, oo, rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        r.valid = v;
        f = (!v || k == OP_ASYNC_EXIT) && ((rnd() & 3) == 0);
        i_sample_pending = 1'(rnd());
        i_status_clear = !v && ((rnd() & 7) == 0);
        i_sib_fixed_any = 3'(rnd());
        i_sib_gp_any = 8'(rnd());
        i_sib_opt_out = 1'(rnd());
        i_shared_cnt_en = 1'(rnd());
        i_exit_window = 1'(rnd());
        i_store_evt.fault_like = f;
        i_store_evt.trap_like = i_exit_window && ((rnd() & 3) == 0);
        i_boundary = !i_store_evt.trap_like && ((rnd() & 3) == 0);
        if (v)
            u_core.put(r);
        else
            u_core.idle();
        e_sv = 1'b0;
        e_inc = 2'h0;
        e_go = v && k == OP_ASYNC_EXIT;
        if (v)
        begin
            case (k)
                OP_ENTER_RESUME:
                begin
                    e_sv = i_sample_pending && !oo;
                    e_sa = r.instr_addr;
                    e_inc = oo ? 2'h0 : RETIRE_ONE;
                    in_oo = oo;
                    last_a = r.instr_addr;
                end
                OP_EXIT_LEAF, OP_ASYNC_EXIT:
                begin
                    e_sa = in_oo ? last_a : (k == OP_EXIT_LEAF ? r.instr_addr : r.saved_state_addr);
                    e_sv = i_sample_pending && !(k == OP_ASYNC_EXIT && f);
                    e_inc = RETIRE_ONE;
                    in_oo = 1'b0;
                end
                OP_EXIT_DELIVERY_END:
                begin
                    e_sv = i_sample_pending;
                    e_sa = r.landing_addr;
                end
                default:
                begin
                    e_sv = i_sample_pending && !in_oo;
                    e_sa = r.instr_addr;
                end
            endcase
        end
        e_st = in_oo || (e_st && !i_status_clear);
        e_sfx = in_oo ? 3'h0 : i_sib_fixed_any;
        e_sgp = in_oo ? 8'h00 : i_sib_gp_any;
        e_sh = i_shared_cnt_en;
        e_ab = f;
        e_rep = f && !i_exit_window;
        e_tr = i_boundary && ptrap;
        ptrap = (ptrap && !i_boundary) || i_store_evt.trap_like;
    endtask : step

    initial
    begin
        i_clk = 1'b0;
        i_rstn = 1'b0;
        {i_sample_pending, i_status_clear, i_sib_opt_out, i_shared_cnt_en, i_exit_window, i_boundary} = '0;
        {i_sib_fixed_any, i_sib_gp_any, i_store_evt} = '0;
        {in_oo, e_st, e_sv, e_ab, e_rep, e_tr, e_go, ptrap, e_sh, e_sfx, e_sgp, e_inc, e_sa, last_a} = '0;
        u_core.idle();
        repeat (16) @(posedge i_clk);
        #1;
        i_rstn = 1'b1;
        repeat (300)
        begin
            step(OP_ENTER_RESUME, 1'b1, 1'(rnd()));
            repeat (rnd() % 3)
                step(rnd() % 2 ? OP_KEY_OR_REPORT : OP_SUPERVISOR, 1'(rnd()), 1'b0);
            if (rnd() % 2)
            begin
                step(OP_ASYNC_EXIT, 1'b1, 1'b0);
                step(OP_EXIT_DELIVERY_END, 1'b1, 1'b0);
            end
            else
                step(OP_EXIT_LEAF, 1'b1, 1'b0);
            step(OP_OTHER, 1'(rnd()), 1'b0);
        end
        step(OP_OTHER, 1'b0, 1'b0);
        give_verdict();
    end

    // Hang guard, well above the longest sequence
    initial
    begin
        repeat (100000) @(posedge i_clk);
        err_total++;
        give_verdict();
    end
endmodule : tb
